// >>> src/tip_pkg.sv
package tip_pkg;
    localparam logic [6:0] TIP_DEF_ADDR = 7'h55;
    localparam logic [7:0] TIP_DEF_REG = 8'h10;
    localparam int TIP_REPORT_LEN = 42;
    // Report layout, offsets relative to the report start
    localparam logic [7:0] TIP_OFS_FINGERS = 8'h00;
    localparam logic [7:0] TIP_OFS_P0 = 8'h02;
    localparam logic [7:0] TIP_OFS_P1 = 8'h07;
    // Entry: valid, x_h, x_l, y_h, y_l
    localparam int TIP_REG_WORDS = 256;
endpackage : tip_pkg

// >>> src/tip_sync.sv
`timescale 1ns/1ps
// ************************************************************
// Two-stage synchroniser with edge detection
// ************************************************************
module tip_sync (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q, sync_q, old_q;
    logic meta_d, sync_d, old_d;

    // Next values; meta_q is read only by sync_q and by its own hold when ce is low
    always_comb begin
        meta_d = ce ? din : meta_q;
        sync_d = ce ? meta_q : sync_q;
        old_d = ce ? sync_q : old_q;
    end

    // Idle bus level is high
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            old_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            old_q <= old_d;
        end
    end

    assign level = sync_q;
    assign rise = ce & sync_q & ~old_q;
    assign fall = ce & ~sync_q & old_q;
endmodule : tip_sync

// >>> src/tip_i2c_slave.sv
`timescale 1ns/1ps
module tip_i2c_slave #(
    parameter logic [6:0] ADDR_DEFAULT = tip_pkg::TIP_DEF_ADDR
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_load,
    input wire logic [6:0] addr_new,
    input wire logic touch_valid,
    input wire logic [1:0] touch_fingers,
    input wire logic pt0_valid,
    input wire logic [15:0] pt0_x,
    input wire logic [15:0] pt0_y,
    input wire logic pt1_valid,
    input wire logic [15:0] pt1_x,
    input wire logic [15:0] pt1_y,
    output logic int_n,
    output logic [6:0] slave_addr
);
    import tip_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_ACK = 3'b010,
        ST_SEND = 3'b011,
        ST_MACK = 3'b100,
        ST_SKIP = 3'b101
    } tip_state_t;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    logic scl_s, scl_r, scl_f, sda_s, sda_r, sda_f;
    tip_sync u_scl (.core_clk(core_clk), .reset_n(reset_n), .ce(ce),
        .din(scl_in), .level(scl_s), .rise(scl_r), .fall(scl_f));
    tip_sync u_sda (.core_clk(core_clk), .reset_n(reset_n), .ce(ce),
        .din(sda_in), .level(sda_s), .rise(sda_r), .fall(sda_f));

    wire start_c = sda_f & scl_s;
    wire stop_c = sda_r & scl_s;

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] regs_q [TIP_REG_WORDS];
    logic [7:0] regs_d [TIP_REG_WORDS];
    tip_state_t st_q, st_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d;    // 0 header, 1 reg addr, 2 data
    logic rd_q, rd_d;
    logic [7:0] start_q, start_d;
    logic [7:0] ptr_q, ptr_d;
    logic sda_out_q, sda_out_d, sda_oe_q, sda_oe_d;
    logic int_n_q, int_n_d;
    logic [6:0] addr_q, addr_d;

    function automatic logic [7:0] nxt(input logic [7:0] a);
        nxt = a + 8'h01;
    endfunction : nxt

    // Coordinate report and register reads share one store
    always_comb begin
        regs_d = regs_q;
        if (touch_valid) begin
            regs_d[TIP_DEF_REG + TIP_OFS_FINGERS] =
                {6'h00, touch_fingers};
            regs_d[TIP_DEF_REG + TIP_OFS_P0] = {7'h00, pt0_valid};
            regs_d[TIP_DEF_REG + TIP_OFS_P0 + 8'h01] = pt0_x[15:8];
            regs_d[TIP_DEF_REG + TIP_OFS_P0 + 8'h02] = pt0_x[7:0];
            regs_d[TIP_DEF_REG + TIP_OFS_P0 + 8'h03] = pt0_y[15:8];
            regs_d[TIP_DEF_REG + TIP_OFS_P0 + 8'h04] = pt0_y[7:0];
            regs_d[TIP_DEF_REG + TIP_OFS_P1] = {7'h00, pt1_valid};
            regs_d[TIP_DEF_REG + TIP_OFS_P1 + 8'h01] = pt1_x[15:8];
            regs_d[TIP_DEF_REG + TIP_OFS_P1 + 8'h02] = pt1_x[7:0];
            regs_d[TIP_DEF_REG + TIP_OFS_P1 + 8'h03] = pt1_y[15:8];
            regs_d[TIP_DEF_REG + TIP_OFS_P1 + 8'h04] = pt1_y[7:0];
        end
        if (st_q == ST_RECV && scl_f && bit_q == 4'd8 && byte_q == 2'd2
                && !rd_q)
            regs_d[ptr_q] = sh_q;
    end

    // Protocol next-state
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bit_d = bit_q;
        byte_d = byte_q;
        rd_d = rd_q;
        start_d = start_q;
        ptr_d = ptr_q;
        sda_out_d = sda_out_q;
        sda_oe_d = sda_oe_q;
        int_n_d = int_n_q;
        addr_d = addr_q;
        if (addr_load)
            addr_d = addr_new;
        // New report raises request; serviced by a read access
        if (touch_valid)
            int_n_d = 1'b0;
        if (start_c) begin
            st_d = ST_RECV;
            bit_d = 4'd0;
            byte_d = 2'd0;
            sda_oe_d = 1'b0;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE, ST_SKIP: ;
                ST_RECV: begin
                    if (scl_r && bit_q < 4'd8) begin
                        sh_d = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'd1;
                    end else if (scl_f && bit_q == 4'd8) begin
                        bit_d = 4'd0;
                        if (byte_q == 2'd0) begin
                            rd_d = sh_q[0];
                            if (sh_q[7:1] == addr_q) begin
                                st_d = ST_ACK;
                                sda_oe_d = 1'b1;
                                sda_out_d = 1'b0;
                                byte_d = 2'd1;
                                ptr_d = start_q;
                                // A fresh report in the same cycle wins
                                if (sh_q[0] && !touch_valid)
                                    int_n_d = 1'b1;
                            end else begin
                                st_d = ST_SKIP;
                            end
                        end else begin
                            st_d = ST_ACK;
                            sda_oe_d = 1'b1;
                            sda_out_d = 1'b0;
                            if (byte_q == 2'd1) begin
                                start_d = sh_q;
                                ptr_d = sh_q;
                                byte_d = 2'd2;
                            end else begin
                                ptr_d = nxt(ptr_q);
                            end
                        end
                    end
                end
                ST_ACK: if (scl_f) begin
                    if (rd_q) begin
                        st_d = ST_SEND;
                        sda_oe_d = ~regs_q[ptr_q][7];
                        sda_out_d = 1'b0;
                        sh_d = {regs_q[ptr_q][6:0], 1'b0};
                        bit_d = 4'd1;
                        ptr_d = nxt(ptr_q);
                    end else begin
                        st_d = ST_RECV;
                        sda_oe_d = 1'b0;
                    end
                end
                ST_SEND: if (scl_f) begin
                    if (bit_q == 4'd8) begin
                        st_d = ST_MACK;
                        sda_oe_d = 1'b0;
                    end else begin
                        sda_oe_d = ~sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                        bit_d = bit_q + 4'd1;
                    end
                end
                ST_MACK: if (scl_r) begin
                    // Host nack ends the burst until the next start or stop
                    st_d = sda_s ? ST_SKIP : ST_ACK;
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    // Open-drain: only ever drives low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            rd_q <= 1'b0;
            start_q <= TIP_DEF_REG;
            ptr_q <= TIP_DEF_REG;
            sda_out_q <= 1'b0;
            sda_oe_q <= 1'b0;
            int_n_q <= 1'b1;
            addr_q <= ADDR_DEFAULT;
        end else if (ce) begin
            st_q <= st_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            rd_q <= rd_d;
            start_q <= start_d;
            ptr_q <= ptr_d;
            sda_out_q <= sda_out_d;
            sda_oe_q <= sda_oe_d;
            int_n_q <= int_n_d;
            addr_q <= addr_d;
        end
    end

    // Register store has no reset; contents undefined until written
    always_ff @(posedge core_clk) begin
        if (ce)
            regs_q <= regs_d;
    end

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign int_n = int_n_q;
    assign slave_addr = addr_q;
endmodule : tip_i2c_slave

// >>> verif/tip_i2c_props.sv
`timescale 1ns/1ps
// ****
// Port checker of the register port slave
// ****
module tip_i2c_props (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic addr_load,
    input wire logic [6:0] addr_new,
    input wire logic touch_valid,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic int_n,
    input wire logic [6:0] slave_addr
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // A pulled-low bit stands a whole bit period, jitter allowed
    sequence s_low_bit;
        sda_oe [*6];
    endsequence
    pin_low_only_a: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    addr_load_a: assert property (
        addr_load |=> slave_addr == $past(addr_new))
        else $error("address not loaded");
    addr_keep_a: assert property (
        !addr_load |=> $stable(slave_addr))
        else $error("address moved alone");
    int_set_a: assert property (touch_valid |=> !int_n)
        else $error("int_n not set");
    int_cause_a: assert property (
        $fell(int_n) |-> $past(touch_valid))
        else $error("int_n fell alone");
    int_clear_a: assert property (
        $rose(int_n) |-> sda_oe || $past(sda_oe, 3))
        else $error("int_n cleared without ack");
    oe_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda moved while scl high");
    oe_hold_a: assert property ($rose(sda_oe) |-> s_low_bit)
        else $error("sda low too short");
endmodule : tip_i2c_props

bind tip_i2c_slave tip_i2c_props tip_i2c_props_inst (.core_clk, .reset_n,
    .scl_in, .addr_load, .addr_new, .touch_valid, .sda_out, .sda_oe,
    .int_n, .slave_addr);

// >>> verif/tip_host.sv
`timescale 1ns/1ps
// ****
// Host model: SCL high 3 clocks, low 5, idle between frames
// ****
module tip_host (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // Bus rests with SCL high and SDA released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge core_clk);
    endtask : w
    task automatic start();
        sda_pull = 1'b1;
        w(3);
        scl = 1'b0;
        w(3);
    endtask : start
    task automatic stop();
        sda_pull = 1'b1;
        w(2);
        scl = 1'b1;
        w(3);
        sda_pull = 1'b0;
        w(8);
    endtask : stop
    // Data moves mid-low so the slave's sync delay cannot race SCL
    task automatic bit_x(input logic b, output logic r);
        sda_pull = !b;
        w(2);
        scl = 1'b1;
        w(2);
        r = sda;
        w(1);
        scl = 1'b0;
        w(3);
    endtask : bit_x
    // MSB first, then the ninth bit (own ack out, slave ack in)
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(a, ak);
    endtask : xfer
endmodule : tip_host

// >>> verif/touch_i2c_register_port_tb.sv
`timescale 1ns/1ps
module touch_i2c_register_port_tb;
    import tip_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic addr_load = 1'b0;
    logic touch_valid = 1'b0;
    logic scl, sda_pull, sda, sda_out, sda_oe, int_n, ak;
    logic pt0_valid, pt1_valid;
    logic [1:0] fingers;
    logic [6:0] addr_new = 7'h2A;
    logic [6:0] slave_addr, dev;
    logic [15:0] pt0_x, pt0_y, pt1_x, pt1_y;
    logic [7:0] rb;
    logic [7:0] mem [256];
    logic [31:0] seed = 32'h4A;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 core_clk = ~core_clk;
    // Open-drain line with pull-up
    assign sda = !(sda_oe || sda_pull);
    tip_i2c_slave tip_i2c_slave_inst (.core_clk, .reset_n, .ce(1'b1),
        .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_load,
        .addr_new, .touch_valid, .touch_fingers(fingers), .pt0_valid,
        .pt0_x, .pt0_y, .pt1_valid, .pt1_x, .pt1_y, .int_n, .slave_addr);
    tip_host tip_host_inst (.core_clk, .sda, .scl, .sda_pull);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Point entry byte at report offset i
    function automatic logic [7:0] ent(input int i);
        logic [79:0] e;
        e = {7'h00, pt0_valid, pt0_x, pt0_y, 7'h00, pt1_valid, pt1_x, pt1_y};
        return e[79 - 8 * (i - 2) -: 8];
    endfunction : ent
    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic conclude();
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic hdr(input logic [6:0] a, input logic r, input logic ok);
        tip_host_inst.start();
        tip_host_inst.xfer({a, r}, 1'b1, rb, ak);
        cmp("header ack", {7'h00, !ok}, {7'h00, ak});
    endtask : hdr
    // Start address goes first, data lands upward from it
    task automatic wr(input logic [7:0] r, input int n);
        hdr(dev, 1'b0, 1'b1);
        tip_host_inst.xfer(r, 1'b1, rb, ak);
        cmp("reg ack", 8'h00, {7'h00, ak});
        for (int i = 0; i < n; i++) begin
            mem[8'(r + i)] = 8'(xs());
            tip_host_inst.xfer(mem[8'(r + i)], 1'b1, rb, ak);
            cmp("data ack", 8'h00, {7'h00, ak});
        end
        tip_host_inst.stop();
    endtask : wr
    // Last byte is refused by the host to end the read
    task automatic rd(input logic [7:0] a, input int n);
        logic rep;
        rep = (a == TIP_DEF_REG);
        hdr(dev, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            tip_host_inst.xfer(8'hFF, i == n - 1, rb, ak);
            if (rep && i == 0) cmp("fingers", {6'h00, fingers}, rb);
            else if (rep && i > 1 && i < 12)
                cmp("point", ent(i), rb);
            else cmp("reg", mem[8'(a + i)], rb);
        end
        tip_host_inst.stop();
    endtask : rd
    task automatic touch();
        {pt0_x, pt0_y} = xs();
        {pt1_x, pt1_y} = xs();
        {pt0_valid, pt1_valid, fingers} = 4'(xs());
        touch_valid = 1'b1;
        @(negedge core_clk);
        touch_valid = 1'b0;
        @(negedge core_clk);
        cmp("int_n", 8'h00, {7'h00, int_n});
    endtask : touch
    // Hang guard, runs are near 11800 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {pt0_x, pt0_y, pt1_x, pt1_y} = 64'h0;
        {pt0_valid, pt1_valid, fingers} = 4'h0;
        dev = TIP_DEF_ADDR;
        repeat (16) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        cmp("int_n", 8'h01, {7'h00, int_n});
        cmp("address", 8'h55, {1'b0, slave_addr});
        // Start address from reset reaches the report with no write
        touch();
        rd(TIP_DEF_REG, 1);
        // Fill the report so no unwritten byte is ever shifted out
        wr(TIP_DEF_REG, TIP_REPORT_LEN);
        for (int k = 0; k < 2; k++) begin
            touch();
            rd(TIP_DEF_REG, TIP_REPORT_LEN);
            cmp("int_n", 8'h01, {7'h00, int_n});
        end
        hdr(7'h22, 1'b0, 1'b0);
        tip_host_inst.stop();
        wr(8'h40, 4);
        wr(8'h40, 0);
        rd(8'h40, 4);
        rd(8'h40, 4);
        addr_load = 1'b1;
        @(negedge core_clk);
        addr_load = 1'b0;
        @(negedge core_clk);
        dev = addr_new;
        cmp("address", {1'b0, dev}, {1'b0, slave_addr});
        hdr(TIP_DEF_ADDR, 1'b0, 1'b0);
        tip_host_inst.stop();
        wr(8'h80, 3);
        rd(8'h80, 3);
        conclude();
    end
endmodule : touch_i2c_register_port_tb
